// ===== src/can_time_trigger_timer.sv
// Free-running frame timer with capture, compare reload and Wishbone slave
// Function
// - Sixteen-bit count, host readable and writable
// - Count increments while running; after enable clears it runs on to the next overflow/match
// - Compare-zero match with compare-clear bit set reloads local offset, keeps counting
// - Enable bit zero stops, one runs
// - Clearing enable halts at next overflow/match
// - Capture count at every start of frame while capture enable set
// - Capture disabled leaves capture zero unchanged
// - Matched mailbox with auto-disable clears capture enable
// - Timestamp select: zero start, one end
`timescale 1ns/1ps
`include "tt_timer_consts.svh"
module can_time_trigger_timer #(
  parameter int CW = 16
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          frame_start,
  input  wire logic          frame_end,
  input  wire logic          mailbox_id_compare_flag,
  output logic [CW-1:0]      timestamp_capture_one,
  output logic               timer_running,
  output logic               compare_zero_match
);
  import tt_timer_pkg::*;

  logic [CW-1:0]  timer_count;
  logic [15:0]    timer_control;
  logic [CW-1:0]  compare_register_zero;
  logic [CW-1:0]  local_offset_value;
  logic [CW-1:0]  input_capture_zero;
  run_state_type  run_state;
  run_state_type  next_run_state;
  logic [2:0]     ev_rise;

  // Frame pins are asynchronous to the core clock; two stages come first
  frame_event_sync #(.WIDTH(3)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({mailbox_id_compare_flag, frame_end, frame_start}),
    .rise     (ev_rise)
  );

  wire sof_evt = ev_rise[0];
  wire eof_evt = ev_rise[1];
  wire ccm_evt = ev_rise[2];

  // Bus decode; registers answer one cycle after the request is seen
  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = req & wb_we_i;
  wire lo_en    = wb_sel_i[0];
  wire hi_en    = wb_sel_i[1];
  wire wr_count = wr & (wb_adr_i == `OFS_TIMER_COUNT);
  wire wr_ctrl  = wr & (wb_adr_i == `OFS_TIMER_CONTROL);
  wire wr_cmp   = wr & (wb_adr_i == `OFS_COMPARE_ZERO);
  wire wr_ofs   = wr & (wb_adr_i == `OFS_LOCAL_OFFSET);

  wire [15:0] wdat_merge_cnt = {hi_en ? wb_dat_i[15:8] : timer_count[15:8],
                                lo_en ? wb_dat_i[7:0]  : timer_count[7:0]};
  wire [15:0] wdat_merge_ctl = {hi_en ? wb_dat_i[15:8] : timer_control[15:8],
                                lo_en ? wb_dat_i[7:0]  : timer_control[7:0]};
  wire [15:0] wdat_merge_cmp = {hi_en ? wb_dat_i[15:8]
                                      : compare_register_zero[15:8],
                                lo_en ? wb_dat_i[7:0]
                                      : compare_register_zero[7:0]};
  wire [15:0] wdat_merge_ofs = {hi_en ? wb_dat_i[15:8]
                                      : local_offset_value[15:8],
                                lo_en ? wb_dat_i[7:0]
                                      : local_offset_value[7:0]};

  wire en_bit       = timer_control[`BIT_TIMER_ENABLE];
  wire cap_en       = timer_control[`BIT_CAPTURE_ENABLE];
  wire rx_ts_sel    = timer_control[`BIT_RX_TS_SELECT];
  wire cmp_clr_opt  = timer_control[`BIT_COMPARE_CLEAR];
  wire ccm_clr_opt  = timer_control[`BIT_CCM_CLEAR];
  wire auto_dis_opt = timer_control[`BIT_AUTO_DISABLE];

  wire counting    = (run_state == RUN_ACTIVE);
  wire cmp_hit     = counting & (timer_count == compare_register_zero);
  wire ovf_hit     = counting & (timer_count == {CW{1'b1}});
  wire cmp_reload  = cmp_hit & cmp_clr_opt;
  wire ccm_reload  = counting & ccm_evt & ccm_clr_opt;
  wire auto_clear  = ccm_evt & auto_dis_opt;
  // Stop only at a boundary once enable has been dropped
  wire halt_point  = cmp_hit | ovf_hit;

  // Wraps by width, so overflow needs no logic of its own
  wire [CW-1:0] count_plus = timer_count + {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] next_count =
      wr_count ? wdat_merge_cnt[CW-1:0] :
      (cmp_reload | ccm_reload) ? local_offset_value :
      counting ? count_plus : timer_count;

  wire ts_trigger = rx_ts_sel ? eof_evt : sof_evt;

  wire [15:0] ctrl_written = wdat_merge_ctl & `CONTROL_WRITE_MASK;
  wire [15:0] ctrl_base    = wr_ctrl ? ctrl_written : timer_control;
  // Hardware clear of capture enable wins over a simultaneous write
  wire [15:0] next_control =
      auto_clear ? (ctrl_base & ~(16'h0001 << `BIT_CAPTURE_ENABLE))
                 : ctrl_base;

  wire [31:0] rd_mux =
      (wb_adr_i == `OFS_TIMER_COUNT)   ? {16'h0000, timer_count} :
      (wb_adr_i == `OFS_TIMER_CONTROL) ? {16'h0000, timer_control} :
      (wb_adr_i == `OFS_COMPARE_ZERO)  ? {16'h0000, compare_register_zero} :
      (wb_adr_i == `OFS_LOCAL_OFFSET)  ? {16'h0000, local_offset_value} :
      (wb_adr_i == `OFS_CAPTURE_ZERO)  ? {16'h0000, input_capture_zero} :
      (wb_adr_i == `OFS_CAPTURE_ONE)   ? {16'h0000, timestamp_capture_one} :
      32'h0000_0000;

  always_comb begin
    next_run_state = run_state;
    case (run_state)
      RUN_STOPPED: begin
        if (en_bit) begin
          next_run_state = RUN_ACTIVE;
        end
      end
      RUN_ACTIVE: begin
        if (!en_bit && halt_point) begin
          next_run_state = RUN_STOPPED;
        end
      end
      default: next_run_state = RUN_STOPPED;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_state <= RUN_STOPPED;
      timer_count <= `RESET_COUNT;
      timer_control <= `RESET_CONTROL;
    end else begin
      run_state <= next_run_state;
      timer_count <= next_count;
      timer_control <= next_control;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      compare_register_zero <= `RESET_REG;
      local_offset_value <= `RESET_REG;
    end else begin
      if (wr_cmp) begin
        compare_register_zero <= wdat_merge_cmp[CW-1:0];
      end
      if (wr_ofs) begin
        local_offset_value <= wdat_merge_ofs[CW-1:0];
      end
    end
  end

  // Capture one has no enable of its own; it is always armed
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      input_capture_zero <= `RESET_REG;
      timestamp_capture_one <= `RESET_REG;
    end else begin
      if (cap_en && sof_evt) begin
        input_capture_zero <= timer_count;
      end
      if (ts_trigger) begin
        timestamp_capture_one <= timer_count;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      timer_running <= 1'b0;
      compare_zero_match <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
      timer_running <= (next_run_state == RUN_ACTIVE);
      compare_zero_match <= cmp_hit;
    end
  end

  // Counter checks
  a_count_steps: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (counting && !wr_count && !cmp_reload && !ccm_reload)
      |=> timer_count == $past(timer_count) + 16'h0001)
    else $error("count did not step");

  a_stopped_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!counting && !wr_count) |=> $stable(timer_count))
    else $error("stopped count moved");

  a_start_run: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!counting && en_bit) |=> counting)
    else $error("enabled timer did not start");

  a_cmp_reload: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cmp_reload && !wr_count)
      |=> timer_count == $past(local_offset_value))
    else $error("compare reload missing");

  a_match_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmp_hit |=> compare_zero_match)
    else $error("compare match pulse missing");

  a_wrap_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (ovf_hit && !cmp_reload && !ccm_reload && !wr_count)
      |=> timer_count == 16'h0000)
    else $error("overflow did not wrap");

  a_halt_point: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (counting && !en_bit && !halt_point) |=> counting)
    else $error("halted before boundary");

  a_halt_done: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (counting && !en_bit && halt_point) |=> !counting)
    else $error("did not halt at boundary");

  a_wrap_stop: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (counting && !en_bit && ovf_hit && !cmp_reload && !wr_count)
      |=> (!counting && timer_count == 16'h0000))
    else $error("did not stop on wrap");

  // Capture and timestamp checks
  a_capture_sof: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cap_en && sof_evt)
      |=> input_capture_zero == $past(timer_count))
    else $error("capture missed");

  a_capture_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !cap_en |=> $stable(input_capture_zero))
    else $error("capture changed while disabled");

  a_auto_disable: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    auto_clear |=> !timer_control[`BIT_CAPTURE_ENABLE])
    else $error("capture enable not cleared");

  a_ts_select: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (rx_ts_sel && eof_evt)
      |=> timestamp_capture_one == $past(timer_count))
    else $error("end of frame timestamp missed");

  a_ts_sof: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!rx_ts_sel && sof_evt)
      |=> timestamp_capture_one == $past(timer_count))
    else $error("start of frame timestamp missed");

  a_ts_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !ts_trigger |=> $stable(timestamp_capture_one))
    else $error("timestamp moved without trigger");

  // Bus checks
  a_host_write: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wr_count && lo_en && hi_en)
      |=> timer_count == $past(wb_dat_i[15:0]))
    else $error("count write lost");

  a_ctrl_write: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wr_ctrl && !auto_clear && lo_en && hi_en)
      |=> timer_control == ($past(wb_dat_i[15:0]) & `CONTROL_WRITE_MASK))
    else $error("control write lost");

  a_ack_follows: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_pulse: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");

  a_ack_idle: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without request");
endmodule

// ===== src/tt_timer_consts.svh
// Register offsets, field positions, reset values for the frame timer
`ifndef TT_TIMER_CONSTS_SVH
`define TT_TIMER_CONSTS_SVH

`define OFS_TIMER_COUNT      4'h0
`define OFS_TIMER_CONTROL    4'h1
`define OFS_COMPARE_ZERO     4'h2
`define OFS_LOCAL_OFFSET     4'h3
`define OFS_CAPTURE_ZERO     4'h4
`define OFS_CAPTURE_ONE      4'h5

`define BIT_TIMER_ENABLE     15
`define BIT_CAPTURE_ENABLE   14
`define BIT_RX_TS_SELECT     13
`define BIT_TX_TS_SELECT     12
`define BIT_COMPARE_CLEAR    11
`define BIT_CCM_CLEAR        10
`define BIT_AUTO_DISABLE     9

`define CONTROL_WRITE_MASK   16'hfe3f
`define RESET_COUNT          16'h0000
`define RESET_CONTROL        16'h0000
`define RESET_REG            16'h0000

`endif

// ===== src/tt_timer_pkg.sv
// Types shared by the frame timer files
package tt_timer_pkg;
  typedef enum logic [1:0] {
    RUN_STOPPED = 2'b01,
    RUN_ACTIVE  = 2'b10
  } run_state_type;
endpackage

// ===== src/frame_event_sync.sv
// Two-stage synchroniser and rising-edge detector for frame event pins
`timescale 1ns/1ps
module frame_event_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] last;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          meta[i]   <= 1'b0;
          stable[i] <= 1'b0;
          last[i]   <= 1'b0;
        end else begin
          meta[i]   <= async_in[i];
          stable[i] <= meta[i];
          last[i]   <= stable[i];
        end
      end
      // Only the second stage feeds the edge detector
      assign rise[i] = stable[i] & ~last[i];
    end
  endgenerate
endmodule

// ===== tb/frame_event_model.sv
// Frame event source standing in for the CAN protocol engine
`timescale 1ns/1ps
module frame_event_model (
  input  wire logic       core_clk,
  input  wire logic [2:0] req,
  output logic      [2:0] pins
);
  logic [2:0] d1 = 3'h0;
  logic [2:0] d2 = 3'h0;
  logic [2:0] d3 = 3'h0;
  // Three cycles high, so the two-stage synchroniser never misses an event
  always @(posedge core_clk) begin
    d1 <= req;
    d2 <= d1;
    d3 <= d2;
  end
  assign pins = d1 | d2 | d3;
endmodule

// ===== tb/can_time_trigger_timer_tb.sv
// Self-checking bench for the frame timer
`timescale 1ns/1ps
module can_time_trigger_timer_tb;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  req = 3'h0;
  logic [2:0]  pins;
  logic [15:0] ts_one;
  logic        running;
  logic [15:0] q;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  lanes = 4'h3;
  logic        cmp_match;
  int          match_cnt = 0;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #5 core_clk = ~core_clk;

  can_time_trigger_timer dut_u (
    .core_clk                (core_clk),
    .reset_n                 (reset_n),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .frame_start             (pins[0]),
    .frame_end               (pins[1]),
    .mailbox_id_compare_flag (pins[2]),
    .timestamp_capture_one   (ts_one),
    .timer_running           (running),
    .compare_zero_match      (cmp_match)
  );

  frame_event_model far_u (
    .core_clk (core_clk),
    .req      (req),
    .pins     (pins)
  );

  // Counts compare-zero pulses as the timer runs
  always @(posedge core_clk) begin
    if (cmp_match === 1'b1) begin
      match_cnt <= match_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until the edge that samples ack, released right after
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [15:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= lanes;
    wb_dat_i <= {16'h0, d};
    // No fixed answer time assumed; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input string nm);
    wb(1'b0, a, 16'h0);
    chk(nm, e, q);
  endtask

  task automatic ev(input int i);
    @(posedge core_clk);
    req[i] <= 1'b1;
    @(posedge core_clk);
    req[i] <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(4'h0, 16'h0000, "count reset");
    rd(4'h1, 16'h0000, "control reset");
    wr(4'h1, 16'h01ff);
    rd(4'h1, 16'h003f, "control bits");
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h0000, "unmapped");
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h1234);
    repeat (20) @(posedge core_clk);
    rd(4'h0, 16'h1234, "count held");
    lanes = 4'h1;
    wr(4'h0, 16'habcd);
    lanes = 4'h3;
    rd(4'h0, 16'h12cd, "low lane only");
    chk("stopped", 16'h0000, {15'h0, running});
    // Disabled just after the wrap: must run on to compare, not stop
    wr(4'h0, 16'hfff0);
    wr(4'h2, 16'h0020);
    wr(4'h1, 16'h8000);
    repeat (3) @(posedge core_clk);
    chk("running", 16'h0001, {15'h0, running});
    repeat (16) @(posedge core_clk);
    wr(4'h1, 16'h0000);
    repeat (60) @(posedge core_clk);
    // The match edge still steps once, so the count stands one past
    rd(4'h0, 16'h0021, "wrap then halt");
    chk("halted", 16'h0000, {15'h0, running});
    chk("compare pulses", 16'h0001, match_cnt[15:0]);
    wr(4'h0, 16'hfff8);
    wr(4'h1, 16'h8000);
    wr(4'h1, 16'h0000);
    repeat (20) @(posedge core_clk);
    rd(4'h0, 16'h0000, "halt at wrap");
    wr(4'h3, 16'h0010);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h8800);
    repeat (100) @(posedge core_clk);
    wb(1'b0, 4'h0, 16'h0);
    chk("reload window", 16'h0001,
        {15'h0, (q >= 16'h0010) && (q <= 16'h0020)});
    wr(4'h1, 16'h0800);
    repeat (40) @(posedge core_clk);
    rd(4'h0, 16'h0010, "halt on reload");
    wr(4'h1, 16'h4000);
    wr(4'h0, 16'h5555);
    ev(0);
    rd(4'h4, 16'h5555, "capture on sof");
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h6666);
    ev(0);
    rd(4'h4, 16'h5555, "capture held");
    wr(4'h1, 16'h4200);
    ev(2);
    rd(4'h1, 16'h0200, "auto disable");
    wr(4'h0, 16'h1111);
    ev(0);
    chk("stamp on sof", 16'h1111, ts_one);
    rd(4'h4, 16'h5555, "capture after auto off");
    wr(4'h1, 16'h2000);
    wr(4'h0, 16'h2222);
    ev(0);
    rd(4'h5, 16'h1111, "stamp skips sof");
    ev(1);
    rd(4'h5, 16'h2222, "stamp on eof");
    wr(4'h1, 16'h0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(4'h0, 16'h0000, "count after reset");
    rd(4'h4, 16'h0000, "capture after reset");
    rd(4'h5, 16'h0000, "stamp after reset");
    close_out();
  end
endmodule
